// ### src/ptt_map.vh
// Purpose: register map and constants of the periodic tick timer
// Assumes: Wishbone word addressing, word offsets on ADR_I[4:2]
// Notes: definitions only
`ifndef PTT_MAP_VH
`define PTT_MAP_VH
`define PTT_OFS_CTRL 3'h0
`define PTT_OFS_CNTH 3'h1
`define PTT_OFS_CNTL 3'h2
`define PTT_OFS_LIMH 3'h3
`define PTT_OFS_LIML 3'h4
`define PTT_BIT_WRAP 7
`define PTT_BIT_IRQEN 6
`define PTT_BIT_HALT 5
`define PTT_BIT_CLR 4
`define PTT_DIV_LO 0
`define PTT_DIV_HI 2
`define PTT_DIV_MAX 3'h6
`define PTT_LIM_RST 16'hFFFF
`define PTT_CNT_ZERO 16'h0000
`define PTT_PRE_ZERO 6'h00
`define PTT_BYTE_ZERO 8'h00
`define PTT_CTRL_RD_MASK 8'hE7
`define PTT_DIV_RST 3'h0
`define PTT_HALT_RST 1'h1
`define PTT_SEL_LANE 0
`define PTT_HB_HI 15
`define PTT_HB_LO 8
`define PTT_LB_HI 7
`define PTT_LB_LO 0
`define PTT_PRE_ONE 6'h01
`define PTT_CNT_ONE 16'h0001
`define PTT_WORD_ZERO 32'h00000000
`define PTT_PAD_ZERO 24'h000000
`endif

// ### src/ptt_timer.v
// Purpose: periodic tick timer with Wishbone register access
// Assumes: 50 MHz MCLK_I, synchronous active-high reset, break from same clock
// Notes: ack one cycle after a taken strobe; one byte lane per register
//
// Implementation choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ptt_map.vh"
module ptt_timer
(
	input wire MCLK_I, // bus clock
	input wire RST_I, // sync reset, high
	input wire CE_I, // clock enable, freezes all state
	input wire BREAK_I, // break interrupt active
	input wire CYC_I, // wishbone cycle
	input wire STB_I, // wishbone strobe
	input wire WE_I, // write enable
	input wire [3:0] SEL_I, // byte selects
	input wire [4:2] ADR_I, // word address
	input wire [31:0] DAT_I, // write data
	output reg [31:0] DAT_O, // read data
	output reg ACK_O, // acknowledge
	output wire IRQ_O // wrap interrupt request
);
	// Control and status
	reg halt_r;
	reg halt_nxt;
	reg irqen_r;
	reg irqen_nxt;
	reg wrap_r;
	reg wrap_nxt;
	reg arm_r;
	reg arm_nxt;
	reg [2:0] div_r;
	reg [2:0] div_nxt;

	// Timing chain
	reg [5:0] pre_r;
	reg [5:0] pre_nxt;
	reg [15:0] cnt_r;
	reg [15:0] cnt_nxt;

	// Limit and readout buffer
	reg [15:0] lim_r;
	reg [15:0] lim_nxt;
	reg lim_lock_r;
	reg lim_lock_nxt;
	reg [7:0] hold_r;
	reg [7:0] hold_nxt;
	reg hold_v_r;
	reg hold_v_nxt;

	// Bus answer
	reg ack_nxt;
	reg [31:0] dat_nxt;

	// Bus decode
	wire req;
	wire wr;
	wire rd;
	wire wr_ctrl;
	wire rd_ctrl;
	wire rd_cnth;
	wire rd_cntl;
	wire wr_limh;
	wire wr_liml;
	wire clr;
	wire [7:0] wr_byte;

	// Counting
	wire [5:0] tap_mask;
	wire tick;
	wire run;
	wire step;
	wire hit;
	wire wrap_set;
	wire wrap_clr;

	// Readout views
	wire [7:0] ctrl_rd;
	wire [7:0] ctrl_view;
	wire [7:0] cnt_hi_b;
	wire [7:0] cnt_lo_b;
	wire [7:0] lim_hi_b;
	wire [7:0] lim_lo_b;
	wire [7:0] lo_view;

	function is_adr;
		input [2:0] adr;
		input [2:0] ofs;
		begin
			is_adr = (adr == ofs);
		end
	endfunction

	// Codes above the last tap fold onto the slowest rate
	function [5:0] tap_of;
		input [2:0] sel;
		reg [2:0] eff;
		begin
			eff = (sel > `PTT_DIV_MAX) ? `PTT_DIV_MAX : sel;
			tap_of = (`PTT_PRE_ONE << eff) - `PTT_PRE_ONE;
		end
	endfunction

	// Standing ack blocks a second take of the same strobe
	assign req = CYC_I & STB_I & ~ACK_O;
	assign wr = req & WE_I & SEL_I[`PTT_SEL_LANE];
	assign rd = req & ~WE_I;
	assign wr_ctrl = wr & is_adr(ADR_I, `PTT_OFS_CTRL);
	assign rd_ctrl = rd & is_adr(ADR_I, `PTT_OFS_CTRL);
	assign rd_cnth = rd & is_adr(ADR_I, `PTT_OFS_CNTH);
	assign rd_cntl = rd & is_adr(ADR_I, `PTT_OFS_CNTL);
	assign wr_limh = wr & is_adr(ADR_I, `PTT_OFS_LIMH);
	assign wr_liml = wr & is_adr(ADR_I, `PTT_OFS_LIML);
	assign wr_byte = DAT_I[`PTT_LB_HI:`PTT_LB_LO];
	assign clr = wr_ctrl & wr_byte[`PTT_BIT_CLR];

	// Tick when all prescaler bits below the selected tap are ones
	assign tap_mask = tap_of(div_r);
	assign tick = ((pre_r & tap_mask) == tap_mask);
	assign run = ~halt_r & ~BREAK_I;
	assign step = run & tick;
	assign hit = step & (cnt_r == lim_r);
	assign wrap_set = hit & ~lim_lock_r;
	assign wrap_clr = wr_ctrl & arm_r & ~wr_byte[`PTT_BIT_WRAP];

	// Strobe is never stored, so it reads as zero
	assign ctrl_rd = {wrap_r, irqen_r, halt_r, 1'h0, 1'h0, div_r};
	assign ctrl_view = ctrl_rd & `PTT_CTRL_RD_MASK;
	assign cnt_hi_b = cnt_r[`PTT_HB_HI:`PTT_HB_LO];
	assign cnt_lo_b = cnt_r[`PTT_LB_HI:`PTT_LB_LO];
	assign lim_hi_b = lim_r[`PTT_HB_HI:`PTT_HB_LO];
	assign lim_lo_b = lim_r[`PTT_LB_HI:`PTT_LB_LO];
	assign lo_view = hold_v_r ? hold_r : cnt_lo_b;
	assign IRQ_O = wrap_r & irqen_r;

	// Prescaler free-runs; only the strobe restarts it
	always @*
	begin
		pre_nxt = pre_r + `PTT_PRE_ONE;
		if (clr)
			pre_nxt = `PTT_PRE_ZERO;
	end

	always @*
	begin
		cnt_nxt = cnt_r;
		if (clr)
			cnt_nxt = `PTT_CNT_ZERO;
		else if (hit)
			cnt_nxt = `PTT_CNT_ZERO;
		else if (step)
			cnt_nxt = cnt_r + `PTT_CNT_ONE;
	end

	// Set wins over clear so no wrap is lost
	always @*
	begin
		wrap_nxt = wrap_r;
		if (wrap_set)
			wrap_nxt = 1'h1;
		else if (wrap_clr)
			wrap_nxt = 1'h0;
	end

	// Any control write ends the arm, so a stale read cannot clear
	always @*
	begin
		arm_nxt = arm_r;
		if (rd_ctrl)
			arm_nxt = wrap_r;
		else if (wr_ctrl)
			arm_nxt = 1'h0;
	end

	always @*
	begin
		irqen_nxt = irqen_r;
		halt_nxt = halt_r;
		div_nxt = div_r;
		if (wr_ctrl)
		begin
			irqen_nxt = wr_byte[`PTT_BIT_IRQEN];
			halt_nxt = wr_byte[`PTT_BIT_HALT];
			div_nxt = wr_byte[`PTT_DIV_HI:`PTT_DIV_LO];
		end
	end

	// Limit compare takes each byte as written; a high byte write holds off wrap until the low byte write
	always @*
	begin
		lim_nxt = lim_r;
		lim_lock_nxt = lim_lock_r;
		if (wr_limh)
		begin
			lim_nxt[`PTT_HB_HI:`PTT_HB_LO] = wr_byte;
			lim_lock_nxt = 1'h1;
		end
		if (wr_liml)
		begin
			lim_nxt[`PTT_LB_HI:`PTT_LB_LO] = wr_byte;
			lim_lock_nxt = 1'h0;
		end
	end

	// Clear empties the holding buffer so low reads as zero
	always @*
	begin
		hold_nxt = hold_r;
		hold_v_nxt = hold_v_r;
		if (clr)
		begin
			hold_nxt = `PTT_BYTE_ZERO;
			hold_v_nxt = 1'h0;
		end
		else if (rd_cnth & ~hold_v_r)
		begin
			hold_nxt = cnt_lo_b;
			hold_v_nxt = 1'h1;
		end
		else if (rd_cntl)
			hold_v_nxt = 1'h0;
	end

	always @*
	begin
		ack_nxt = req;
	end

	// Data stands with ack only, zero otherwise
	always @*
	begin
		dat_nxt = `PTT_WORD_ZERO;
		if (rd)
		begin
			case (ADR_I)
				`PTT_OFS_CTRL: dat_nxt = {`PTT_PAD_ZERO, ctrl_view};
				`PTT_OFS_CNTH: dat_nxt = {`PTT_PAD_ZERO, cnt_hi_b};
				`PTT_OFS_CNTL: dat_nxt = {`PTT_PAD_ZERO, lo_view};
				`PTT_OFS_LIMH: dat_nxt = {`PTT_PAD_ZERO, lim_hi_b};
				`PTT_OFS_LIML: dat_nxt = {`PTT_PAD_ZERO, lim_lo_b};
				default: dat_nxt = `PTT_WORD_ZERO;
			endcase
		end
	end

	// Low clock enable holds every register, bus answer included
	always @(posedge MCLK_I)
	begin
		if (RST_I)
		begin
			halt_r <= `PTT_HALT_RST;
			irqen_r <= 1'h0;
			wrap_r <= 1'h0;
			arm_r <= 1'h0;
			div_r <= `PTT_DIV_RST;
			pre_r <= `PTT_PRE_ZERO;
			cnt_r <= `PTT_CNT_ZERO;
			lim_r <= `PTT_LIM_RST;
			lim_lock_r <= 1'h0;
			hold_r <= `PTT_BYTE_ZERO;
			hold_v_r <= 1'h0;
			ACK_O <= 1'h0;
			DAT_O <= `PTT_WORD_ZERO;
		end
		else if (CE_I)
		begin
			halt_r <= halt_nxt;
			irqen_r <= irqen_nxt;
			wrap_r <= wrap_nxt;
			arm_r <= arm_nxt;
			div_r <= div_nxt;
			pre_r <= pre_nxt;
			cnt_r <= cnt_nxt;
			lim_r <= lim_nxt;
			lim_lock_r <= lim_lock_nxt;
			hold_r <= hold_nxt;
			hold_v_r <= hold_v_nxt;
			ACK_O <= ack_nxt;
			DAT_O <= dat_nxt;
		end
	end
endmodule
`default_nettype wire

// ### bench/ptt_timer_assertions.sv
// Purpose: bus handshake and readout checks of the tick timer
// Assumes: one clock, synchronous reset
// Notes: bound to ptt_timer below
`timescale 1ns/1ps
`default_nettype none
module ptt_timer_assertions
(
	input wire logic MCLK_I, // clock
	input wire logic RST_I, // reset
	input wire logic CE_I, // enable
	input wire logic CYC_I, // cycle
	input wire logic STB_I, // strobe
	input wire logic WE_I, // write
	input wire logic [4:2] ADR_I, // index
	input wire logic [31:0] DAT_O, // read data
	input wire logic ACK_O, // ack
	input wire logic IRQ_O // irq
);
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (RST_I);
	wire logic req = CYC_I & STB_I & CE_I & !ACK_O;
	property p_ack; req |=> ACK_O; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_ack1; ACK_O && CE_I |=> !ACK_O; endproperty
	a_ack1: assert property (p_ack1) else $error("long ack");
	property p_idle; !ACK_O |-> DAT_O == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("data idle");
	property p_up; ACK_O |-> DAT_O[31:8] == 24'h0; endproperty
	a_up: assert property (p_up) else $error("upper data");
	property p_rd0; req && !WE_I && ADR_I == 3'h0 |=> DAT_O[4:3] == 2'h0; endproperty
	a_rd0: assert property (p_rd0) else $error("strobe reads");
	property p_unm; req && !WE_I && ADR_I > 3'h4 |=> DAT_O == 32'h0; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read");
	property p_irq; $fell(RST_I) |-> !IRQ_O; endproperty
	a_irq: assert property (p_irq) else $error("irq at reset");
	property p_frz; !CE_I |=> $stable(ACK_O) && $stable(DAT_O); endproperty
	a_frz: assert property (p_frz) else $error("not frozen");
endmodule
bind ptt_timer ptt_timer_assertions u_chk(.MCLK_I(MCLK_I), .RST_I(RST_I),
	.CE_I(CE_I), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
	.DAT_O(DAT_O), .ACK_O(ACK_O), .IRQ_O(IRQ_O));
`default_nettype wire

// ### bench/ptt_timer_tb_top.sv
// Purpose: directed register test of the tick timer
// Assumes: one ack per request
// Notes: counts read only while halted or held by break, so timing slack is wide
`timescale 1ns/1ps
`default_nettype none
module ptt_timer_tb_top;
	logic clk = 0, rst = 1, cyc = 0, we = 0, ce = 1, brk = 0;
	logic [2:0] adr = 3'h0;
	logic [31:0] wdat = 32'h0, rdat;
	wire [31:0] dat_o;
	wire ack, irq;
	int fails = 0, check_count = 0;
	initial
	begin
		forever #10 clk = ~clk;
	end
	ptt_timer u_ptt_timer(.MCLK_I(clk), .RST_I(rst), .CE_I(ce),
		.BREAK_I(brk), .CYC_I(cyc), .STB_I(cyc), .WE_I(we), .SEL_I(4'hF),
		.ADR_I(adr), .DAT_I(wdat), .DAT_O(dat_o), .ACK_O(ack), .IRQ_O(irq));
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
		int n = 0;
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		@(posedge clk);
		while (ack !== 1'b1 && n < 20)
		begin
			n++;
			@(posedge clk);
		end
		if (n == 20)
		begin
			fails++;
			final_report();
		end
		else
		begin
			rdat = dat_o;
			cyc <= 1'b0;
			@(posedge clk);
		end
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		cmp(rdat[7:0], exp);
	endtask
	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(3'h0, 8'h20);
		rd(3'h3, 8'hFF);
		rd(3'h4, 8'hFF);
		rd(3'h7, 8'h00);
		bus(1'b1, 3'h3, 8'h00);
		bus(1'b1, 3'h4, 8'h05);
		bus(1'b1, 3'h0, 8'h10);
		repeat (20) @(posedge clk);
		bus(1'b1, 3'h0, 8'h20);
		rd(3'h0, 8'hA0);
		bus(1'b1, 3'h0, 8'hE0);
		rd(3'h0, 8'hE0);
		cmp({7'h0, irq}, 8'h01);
		bus(1'b1, 3'h0, 8'h60);
		rd(3'h0, 8'h60);
		cmp({7'h0, irq}, 8'h00);
		bus(1'b1, 3'h0, 8'h30);
		rd(3'h1, 8'h00);
		rd(3'h2, 8'h00);
		$display("register test done");
		bus(1'b1, 3'h3, 8'h00);
		bus(1'b1, 3'h0, 8'h10);
		repeat (20) @(posedge clk);
		rd(3'h0, 8'h00);
		bus(1'b1, 3'h4, 8'h05);
		repeat (20) @(posedge clk);
		rd(3'h0, 8'h80);
		bus(1'b1, 3'h0, 8'hC0);
		cmp({7'h0, irq}, 8'h01);
		$display("limit lock test done");
		bus(1'b1, 3'h0, 8'h10);
		brk <= 1'b1;
		repeat (10) @(posedge clk);
		rd(3'h1, 8'h00);
		rd(3'h2, 8'h02);
		brk <= 1'b0;
		$display("break test done");
		bus(1'b1, 3'h0, 8'h30);
		bus(1'b1, 3'h4, 8'hFF);
		for (int k = 0; k < 8; k++)
		begin
			bus(1'b1, 3'h0, 8'h10 | 8'(k));
			repeat (127) @(posedge clk);
			bus(1'b1, 3'h0, 8'h20);
			rd(3'h1, 8'h00);
			rd(3'h2, 8'(130 >> (k > 6 ? 6 : k)));
			$display("divide test %0d done", k);
		end
		bus(1'b1, 3'h0, 8'h10);
		ce <= 1'b0;
		repeat (10) @(posedge clk);
		ce <= 1'b1;
		bus(1'b1, 3'h0, 8'h20);
		rd(3'h2, 8'h03);
		bus(1'b1, 3'h0, 8'h00);
		bus(1'b1, 3'h0, 8'h20);
		rd(3'h2, 8'h06);
		$display("enable and resume test done");
		final_report();
	end
endmodule
`default_nettype wire
